// ===== tb/adct_timing_sva.sv
// assertions on the converter timing controller ports
// assumes binding onto adct_timing
`timescale 1ns/1ps
`default_nettype none
module adct_sva #(
  parameter DATA_W = 10
) (
  input wire logic              clock,
  input wire logic              rst,
  input wire logic              start,
  input wire logic              ain_below,
  input wire logic              ain_above,
  input wire logic              busy,
  input wire logic              sampling,
  input wire logic              done,
  input wire logic [15:0]       adc_control_word,
  input wire logic [DATA_W-1:0] ain_code,
  input wire logic [DATA_W-1:0] result
);
  logic [15:0]       cc_pick;
  logic [15:0]       exp_cc;
  logic [15:0]       exp_samp;
  logic [15:0]       n_samp;
  logic [15:0]       n_busy;
  logic [DATA_W-1:0] exp_code;
  // reserved code 01 runs as 00
  always_comb begin
    case (adc_control_word[15:14])
      2'h2:    cc_pick = 16'h0060;
      2'h3:    cc_pick = 16'h0030;
      default: cc_pick = 16'h0018;
    endcase
  end
  // expected lengths from the fields at the taken start
  always_ff @(posedge clock) begin
    if (rst) begin
      exp_cc   <= 16'h0000;
      exp_samp <= 16'h0000;
    end else if (start && !busy) begin
      exp_cc   <= cc_pick;
      exp_samp <= (cc_pick << adc_control_word[13:12]) << 1;
    end
  end
  // phase lengths as seen on the pins
  always_ff @(posedge clock) begin
    if (rst) begin
      n_samp <= 16'h0000;
      n_busy <= 16'h0000;
    end else begin
      n_samp <= sampling ? n_samp + 16'h0001 : 16'h0000;
      n_busy <= busy ? n_busy + 16'h0001 : 16'h0000;
    end
  end
  // last clamped input seen while sampling
  always_ff @(posedge clock) begin
    if (rst)
      exp_code <= '0;
    else if (sampling)
      exp_code <= ain_below ? '0 : (ain_above ? '1 : ain_code);
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_take; start && !busy; endsequence
  sequence s_samp_end; $fell(sampling); endsequence
  sequence s_busy_end; $fell(busy); endsequence
  a_take_busy: assert property (s_take |=> busy && sampling) else $error("no busy");
  a_done_load: assert property (done |-> !busy && $past(busy)) else $error("done");
  a_done_pulse: assert property (done |=> !done) else $error("long done");
  a_result_hold: assert property (!done |-> $stable(result)) else $error("result");
  a_sample_len: assert property (s_samp_end |-> n_samp == exp_samp) else $error("sample");
  a_busy_len: assert property (s_busy_end |-> n_busy == exp_samp + exp_cc * 16'h000E + 16'h0004)
    else $error("busy length");
  a_busy_done: assert property (s_busy_end |-> done) else $error("busy end");
  a_samp_busy: assert property (sampling |-> busy) else $error("idle sample");
  a_hold_input: assert property (done |-> result == exp_code) else $error("hold");
endmodule // adct_sva
bind adct_timing adct_sva #(.DATA_W(DATA_W)) u_sva (
  .clock(clock), .rst(rst), .start(start), .ain_below(ain_below), .ain_above(ain_above),
  .busy(busy), .sampling(sampling), .done(done), .adc_control_word(adc_control_word),
  .ain_code(ain_code), .result(result));
`default_nettype wire

// ===== tb/tb_adc_conversion_timing.sv
// self-checking bench for the converter timing controller
// assumes adct_timing and its checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_adc_conversion_timing;
  logic clock = 0, rst = 1, start = 0, ain_below = 0, ain_above = 0;
  logic [15:0] adc_control_word = 16'h0000;
  logic [9:0] ain_code = 10'h000;
  wire busy, sampling, done;
  wire [9:0] result;
  int num_errors = 0, n_compared = 0, cyc = 0;
  adct_timing uut (.clock(clock), .rst(rst), .adc_control_word(adc_control_word),
    .start(start), .ain_code(ain_code), .ain_below(ain_below), .ain_above(ain_above),
    .busy(busy), .sampling(sampling), .done(done), .result(result));
  always #4 clock = ~clock;
  task wrap_up;
    if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 12000) begin
      num_errors++;
      wrap_up;
    end
  end
  // inputs flipped after sampling, so a late capture shows in result
  task conv(input [1:0] cc, sc, input [9:0] c, input lo, hi, input [9:0] r);
    int n, t, s, nb, ns;
    begin
      t = (cc == 2'h2) ? 96 : (cc == 2'h3) ? 48 : 24;
      s = 2 * t * (1 << sc);
      t = s + 14 * t + 4;
      // a start in the done cycle is legal, so back-to-back runs are covered
      if (done !== 1'b1) @(posedge clock) #1;
      adc_control_word = {cc, sc, 12'h000};
      {ain_code, ain_below, ain_above, start} = {c, lo, hi, 1'b1};
      n = 0;
      nb = 0;
      ns = 0;
      do begin
        @(posedge clock) #1;
        n++;
        // a second start while busy must be ignored
        if (n == 1 || n == 4) start = 0;
        else if (n == 3) start = 1;
        if (busy === 1'b1) nb++;
        if (sampling === 1'b1) ns++;
        if (busy && !sampling) {ain_code, ain_below, ain_above} = {~c, ~lo, ~hi};
      end while (done !== 1'b1 && n < 4000);
      n_compared += 4;
      if (n != t + 1) begin
        num_errors++;
        $display("[ERR] cycles exp %0d seen %0d", t + 1, n);
      end
      if (ns != s) begin
        num_errors++;
        $display("[ERR] sampling exp %0d seen %0d", s, ns);
      end
      if (nb != t) begin
        num_errors++;
        $display("[ERR] busy exp %0d seen %0d", t, nb);
      end
      if (result !== r) begin
        num_errors++;
        $display("[ERR] result exp %h seen %h", r, result);
      end
    end
  endtask
  task t_clocks;
    conv(2'h0, 2'h0, 10'h155, 1'b0, 1'b0, 10'h155);
    conv(2'h1, 2'h0, 10'h0AA, 1'b0, 1'b0, 10'h0AA);
    conv(2'h2, 2'h0, 10'h2AA, 1'b0, 1'b0, 10'h2AA);
    conv(2'h3, 2'h0, 10'h0F0, 1'b0, 1'b0, 10'h0F0);
    for (int s = 1; s < 4; s++) conv(2'h0, s[1:0], 10'h3C3, 1'b0, 1'b0, 10'h3C3);
  endtask
  task t_clamp;
    conv(2'h0, 2'h1, 10'h123, 1'b1, 1'b0, 10'h000);
    conv(2'h0, 2'h0, 10'h123, 1'b0, 1'b1, 10'h3FF);
    conv(2'h0, 2'h0, 10'h123, 1'b1, 1'b1, 10'h000);
  endtask
  initial begin
    repeat (12) @(posedge clock);
    #1 rst = 0;
    t_clocks;
    t_clamp;
    wrap_up;
  end
endmodule // tb_adc_conversion_timing
`default_nettype wire

// ===== verilog/adct_regs.vh
// constants for the converter timing controller
// assumes one clock edge of the design clock stands for one cpu half-period
`ifndef ADCT_REGS_VH
`define ADCT_REGS_VH
`define ADCT_CC_MSB       4'hF
`define ADCT_CC_LSB       4'hE
`define ADCT_SC_MSB       4'hD
`define ADCT_SC_LSB       4'hC
`define ADCT_CNT_CLEAR    16'h0000
`define ADCT_CNT_FIRST    16'h0001
`define ADCT_CNT_STEP     16'h0001
`define ADCT_CC_CODE_24   2'h0
`define ADCT_CC_CODE_RSV  2'h1
`define ADCT_CC_CODE_96   2'h2
`define ADCT_CC_CODE_48   2'h3
`define ADCT_CC_HP_24     16'h0018
`define ADCT_CC_HP_48     16'h0030
`define ADCT_CC_HP_96     16'h0060
`define ADCT_SAMPLE_SC    16'h0002
`define ADCT_CONV_CC      16'h000E
`define ADCT_LOAD_HP      16'h0004
`define ADCT_CODE_ZERO    10'h000
`define ADCT_CODE_FULL    10'h3FF
`endif

// ===== verilog/adct_timing.v
// converter timing controller: sample, conversion and result load sequencing
// assumes start, control word and analog code inputs synchronous to clock
`timescale 1ns/1ps
`default_nettype none
`include "adct_regs.vh"

// How it works
// - conversion clock field bits 15:14 gives 24, 96, 48 half-periods; 01 reserved.
// - sample clock field bits 13:12 multiplies conversion clock by 1, 2, 4, 8.
// - sampling lasts exactly two sample clock periods, fixed each time.
// - total time is 14 conversion clocks plus sample time plus 4 half-periods.
// - input is frozen once sampling ends.
// - below ground reads all zeros, above reference reads all ones.
// - every count is in cpu half-periods, one per clock edge.
// - sampling scales with both select fields, conversion with the conversion clock field only.
module adct_timing #(
  parameter DATA_W = 10
) (
  // clock and reset
  input  wire              clock,
  input  wire              rst,
  // control
  input  wire [15:0]       adc_control_word,
  input  wire              start,
  // analog front end, already quantised
  input  wire [DATA_W-1:0] ain_code,
  input  wire              ain_below,
  input  wire              ain_above,
  // status and result
  output reg               busy,
  output reg               sampling,
  output reg               done,
  output reg  [DATA_W-1:0] result
);

  // sequencer phases
  localparam ST_IDLE = 2'h0;
  localparam ST_SAMP = 2'h1;
  localparam ST_CONV = 2'h2;
  localparam ST_LOAD = 2'h3;

  // counter wide enough for the longest phase, 8 x 2 x 96 half-periods
  localparam CNT_W = 16;
  // one entry per sample clock select code
  localparam SEL_N = 4;

  // sequencer state and phase counter
  reg  [1:0]        state;
  reg  [1:0]        next_state;
  reg  [CNT_W-1:0]  cnt;
  reg  [CNT_W-1:0]  next_cnt;

  // settings latched when a conversion is taken
  reg  [CNT_W-1:0]  cc_hp;
  reg  [CNT_W-1:0]  next_cc_hp;
  reg  [1:0]        sc_sel;
  wire [1:0]        next_sc_sel;

  // sample frozen for the rest of the conversion
  reg  [DATA_W-1:0] held;
  reg  [DATA_W-1:0] next_held;
  reg  [DATA_W-1:0] clamp_code;

  // next values of the registered outputs
  reg               next_busy;
  reg               next_sampling;
  reg               next_done;
  reg  [DATA_W-1:0] next_result;

  // phase lengths and phase end strobes
  wire [CNT_W-1:0]  samp_base;
  wire [CNT_W-1:0]  samp_tab [0:SEL_N-1];
  wire [CNT_W-1:0]  samp_hp;
  wire [CNT_W-1:0]  conv_hp;
  wire              take;
  wire              samp_end;
  wire              conv_end;
  wire              load_end;

  // reserved code 01 runs as code 00 rather than stalling the sequencer
  always @* begin
    case (adc_control_word[`ADCT_CC_MSB:`ADCT_CC_LSB])
      `ADCT_CC_CODE_24: next_cc_hp = `ADCT_CC_HP_24;
      `ADCT_CC_CODE_96: next_cc_hp = `ADCT_CC_HP_96;
      `ADCT_CC_CODE_48: next_cc_hp = `ADCT_CC_HP_48;
      default:          next_cc_hp = `ADCT_CC_HP_24;
    endcase
  end

  assign next_sc_sel = adc_control_word[`ADCT_SC_MSB:`ADCT_SC_LSB];

  // two sample clock periods at select code 00
  assign samp_base = cc_hp * `ADCT_SAMPLE_SC;

  // sample length for each select code
  genvar gi;
  generate
    for (gi = 0; gi < SEL_N; gi = gi + 1) begin : g_samp
      assign samp_tab[gi] = samp_base << gi;
    end
  endgenerate

  assign samp_hp = samp_tab[sc_sel];
  assign conv_hp = cc_hp * `ADCT_CONV_CC;

  // one count per clock edge, each edge one half-period
  assign take     = (state == ST_IDLE) && start;
  assign samp_end = (cnt == samp_hp);
  assign conv_end = (cnt == conv_hp);
  assign load_end = (cnt == `ADCT_LOAD_HP);

  // below ground wins over above reference
  always @* begin
    if (ain_below)
      clamp_code = {DATA_W{1'b0}};
    else if (ain_above)
      clamp_code = {DATA_W{1'b1}};
    else
      clamp_code = ain_code;
  end

  always @* begin
    next_state    = state;
    next_cnt      = cnt;
    next_held     = held;
    next_busy     = busy;
    next_sampling = sampling;
    next_done     = 1'b0;
    next_result   = result;
    case (state)
      ST_IDLE: begin
        // a start while busy is ignored, not queued
        if (take) begin
          next_cnt      = `ADCT_CNT_FIRST;
          next_busy     = 1'b1;
          next_sampling = 1'b1;
          next_state    = ST_SAMP;
        end
      end
      ST_SAMP: begin
        if (samp_end) begin
          // later input changes cannot reach the result
          next_held     = clamp_code;
          next_sampling = 1'b0;
          next_cnt      = `ADCT_CNT_FIRST;
          next_state    = ST_CONV;
        end else begin
          next_cnt = cnt + `ADCT_CNT_STEP;
        end
      end
      ST_CONV: begin
        if (conv_end) begin
          next_cnt   = `ADCT_CNT_FIRST;
          next_state = ST_LOAD;
        end else begin
          next_cnt = cnt + `ADCT_CNT_STEP;
        end
      end
      ST_LOAD: begin
        if (load_end) begin
          next_result = held;
          next_done   = 1'b1;
          next_busy   = 1'b0;
          next_state  = ST_IDLE;
        end else begin
          next_cnt = cnt + `ADCT_CNT_STEP;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // settings only move on a taken start, so a mid-run write cannot stretch a conversion
  always @(posedge clock) begin
    if (rst) begin
      cc_hp  <= `ADCT_CC_HP_24;
      sc_sel <= 2'h0;
    end else if (take) begin
      cc_hp  <= next_cc_hp;
      sc_sel <= next_sc_sel;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      state <= ST_IDLE;
      cnt   <= `ADCT_CNT_CLEAR;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      held <= {DATA_W{1'b0}};
    end else begin
      held <= next_held;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      busy     <= 1'b0;
      sampling <= 1'b0;
      done     <= 1'b0;
    end else begin
      busy     <= next_busy;
      sampling <= next_sampling;
      done     <= next_done;
    end
  end

  // result stands until the next load
  always @(posedge clock) begin
    if (rst) begin
      result <= {DATA_W{1'b0}};
    end else begin
      result <= next_result;
    end
  end

endmodule // adct_timing
`default_nettype wire
